// ---- shared/kwi_pkg.sv ----
package kwi_pkg;

  // Pin count and data widths
  localparam int KWI_PINS = 8;
  localparam int KWI_REG_W = 8;
  localparam int KWI_APB_AW = 16;
  localparam int KWI_APB_DW = 32;

  // Register indices; byte address is four times the index
  localparam logic [KWI_APB_AW-1:0] KWI_IDX_STATUS = 16'h001A;
  localparam logic [KWI_APB_AW-1:0] KWI_IDX_ENABLE = 16'h001B;
  localparam logic [KWI_APB_AW-1:0] KWI_IDX_POLARITY = 16'h0448;

  // Status/control field positions
  localparam int KWI_BIT_MODE = 0;
  localparam int KWI_BIT_MASK = 1;
  localparam int KWI_BIT_ACK = 2;
  localparam int KWI_BIT_FLAG = 3;

  // Reset values
  localparam logic [KWI_REG_W-1:0] KWI_RST_STATUS = 8'h00;
  localparam logic [KWI_REG_W-1:0] KWI_RST_ENABLE = 8'h00;
  localparam logic [KWI_REG_W-1:0] KWI_RST_POLARITY = 8'h00;

  // Keyboard vector location, high byte then low byte
  localparam logic [15:0] KWI_VECTOR_HI = 16'hFFE0;
  localparam logic [15:0] KWI_VECTOR_LO = 16'hFFE1;

endpackage

// ---- shared/kwi_det_if.sv ----
`timescale 1ns/1ps
// Carrier between the register block and the pin detector
interface kwi_det_if #(
  parameter int PINS = 8
);
  logic [PINS-1:0] watch_en;
  logic [PINS-1:0] sense_pol;
  logic [PINS-1:0] pin_level;
  logic [PINS-1:0] pin_asserted;
  logic level_any;
  logic edge_hit;

  modport ctl (
    output watch_en,
    output sense_pol,
    input pin_level,
    input pin_asserted,
    input level_any,
    input edge_hit
  );

  modport det (
    input watch_en,
    input sense_pol,
    output pin_level,
    output pin_asserted,
    output level_any,
    output edge_hit
  );
endinterface

// ---- src/kwi_detect.sv ----
`timescale 1ns/1ps
// Samples the eight pins and finds qualifying edges and held levels
module kwi_detect
  import kwi_pkg::*;
#(
  parameter int PINS = KWI_PINS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [PINS-1:0] pins_async,
  kwi_det_if.det det
);

  typedef struct packed {
    logic [PINS-1:0] meta;
    logic [PINS-1:0] sync;
    logic [PINS-1:0] prev;
  } kwi_det_state_t;

  kwi_det_state_t st_r;
  kwi_det_state_t st_nxt;
  logic [PINS-1:0] asserted_now;
  logic [PINS-1:0] asserted_prev;
  logic [PINS-1:0] new_edge;

  // Fill the next state: two-stage synchroniser, then one bus-cycle history
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = pins_async;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Asserted level per pin; polarity zero means low is asserted
  assign asserted_now = det.watch_en & ~(st_r.sync ^ det.sense_pol);
  assign asserted_prev = det.watch_en & ~(st_r.prev ^ det.sense_pol);
  // Deasserted in one bus cycle, asserted in the next
  assign new_edge = asserted_now & ~asserted_prev;

  assign det.pin_level = st_r.sync;
  assign det.pin_asserted = asserted_now;
  assign det.level_any = |asserted_now;
  // An edge counts only if no other enabled pin is already held asserted
  assign det.edge_hit = (|new_edge) && !(|(asserted_now & ~new_edge));

endmodule

// ---- src/kwi_top.sv ----
// Operation
// - Edge mode ignores edge while another pin held
// - Level mode keeps request while pin asserted
// - Level mode clears after acknowledge and release
// - Vector fetch acknowledges like software acknowledge
// - Unmasked request presents vector FFE0/FFE1
// - Acknowledge bit write-one clears, reads zero
// - Edge after acknowledge latches new request
// - Edge mode acknowledge clears request at once
// - Reset clears request and sense mode
// - Pending flag readable, unaffected by mask
// - Enabled pin forced to input direction
// - Block bit one stops request reaching CPU
// - Sense select one: edge plus level
// - Eight enable bits include or exclude pins
// - Polarity one rising/high, zero falling/low
// - Polarity picks pullup zero, pulldown one
// - Break blocks acknowledge unless clear allowed
// - Detection and wakeup in wait and stop
// - Upper status bits read zero
// - Edge is deasserted sample then asserted
// - Eight pins share one request latch
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module kwi_top
  import kwi_pkg::*;
#(
  parameter int PINS = KWI_PINS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [KWI_APB_AW-1:0] paddr,
  input wire logic [KWI_APB_DW-1:0] pwdata,
  output logic [KWI_APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PINS-1:0] watched_port_pin,
  input wire logic [PINS-1:0] port_direction_bits,
  output logic [PINS-1:0] pin_drive_enable,
  output logic [PINS-1:0] pin_read_data,
  output logic [PINS-1:0] pad_pullup_en,
  output logic [PINS-1:0] pad_pulldown_en,
  input wire logic vector_fetch,
  input wire logic break_active,
  input wire logic break_clear_allow,
  output logic key_irq,
  output logic key_wakeup,
  output logic [15:0] vector_addr_hi,
  output logic [15:0] vector_addr_lo
);

  // Whole module state in one record
  typedef struct packed {
    logic pending;
    logic ack_seen;
    logic block;
    logic sense_sel;
    logic [PINS-1:0] enable;
    logic [PINS-1:0] polarity;
    logic [PINS-1:0] read_pins;
    logic [KWI_APB_DW-1:0] rdata;
    logic irq;
  } kwi_top_state_t;

  kwi_top_state_t st_r;
  kwi_top_state_t st_nxt;

  kwi_det_if #(.PINS(PINS)) det_bus ();

  logic setup_phase;
  logic access_phase;
  logic hit_status;
  logic hit_enable;
  logic hit_polarity;
  logic hit_any;
  logic wr_status;
  logic sw_ack;
  logic ack_now;
  logic [KWI_REG_W-1:0] status_view;

  // Address decode, word aligned; used for three registers
  function automatic logic reg_hit(input logic [KWI_APB_AW-1:0] addr,
                                   input logic [KWI_APB_AW-1:0] idx);
    logic [KWI_APB_AW-1:0] byte_addr;
    byte_addr = {idx[KWI_APB_AW-3:0], 2'b00};
    reg_hit = (addr == byte_addr);
  endfunction

  kwi_detect #(
    .PINS(PINS)
  ) u_detect (
    .pclk(pclk),
    .presetn(presetn),
    .pins_async(watched_port_pin),
    .det(det_bus.det)
  );

  // Detector runs from the live register contents at all times
  assign det_bus.watch_en = st_r.enable;
  assign det_bus.sense_pol = st_r.polarity;

  // Bus phases
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;

  // Register selection
  assign hit_status = reg_hit(paddr, KWI_IDX_STATUS);
  assign hit_enable = reg_hit(paddr, KWI_IDX_ENABLE);
  assign hit_polarity = reg_hit(paddr, KWI_IDX_POLARITY);
  assign hit_any = hit_status || hit_enable || hit_polarity;

  // A write lands on the access edge; slave is always ready
  assign wr_status = access_phase && pwrite && hit_status;
  // Acknowledge during break only counts when the break clear is allowed
  assign sw_ack = wr_status && pwdata[KWI_BIT_ACK] && (!break_active || break_clear_allow);
  // Vector fetch is the hardware acknowledge
  assign ack_now = sw_ack || vector_fetch;

  // Status view: flag, mask, mode; acknowledge and top nibble read zero
  always_comb begin
    status_view = KWI_RST_STATUS;
    status_view[KWI_BIT_FLAG] = st_r.pending;
    status_view[KWI_BIT_ACK] = 1'b0;
    status_view[KWI_BIT_MASK] = st_r.block;
    status_view[KWI_BIT_MODE] = st_r.sense_sel;
  end

  // Next-state logic
  always_comb begin
    st_nxt = st_r;

    // Register writes
    if (access_phase && pwrite) begin
      if (hit_status) begin
        st_nxt.block = pwdata[KWI_BIT_MASK];
        st_nxt.sense_sel = pwdata[KWI_BIT_MODE];
      end
      if (hit_enable) begin
        st_nxt.enable = pwdata[PINS-1:0];
      end
      if (hit_polarity) begin
        st_nxt.polarity = pwdata[PINS-1:0];
      end
    end

    // Request latch; a set in the same cycle as a clear wins
    if (st_r.sense_sel) begin
      // Edge plus level: a held pin keeps it set; clear needs ack and release
      if (det_bus.level_any) begin
        st_nxt.pending = 1'b1;
        if (st_r.pending && ack_now) begin
          st_nxt.ack_seen = 1'b1;
        end
      end else if (st_r.pending && (ack_now || st_r.ack_seen)) begin
        st_nxt.pending = 1'b0;
        st_nxt.ack_seen = 1'b0;
      end
    end else begin
      // Edge only: acknowledge clears regardless of pin levels
      st_nxt.ack_seen = 1'b0;
      if (det_bus.edge_hit) begin
        st_nxt.pending = 1'b1;
      end else if (ack_now) begin
        st_nxt.pending = 1'b0;
      end
    end

    // Read data captured in the setup cycle, presented in the access cycle
    if (setup_phase) begin
      st_nxt.rdata = '0;
      if (hit_status) begin
        st_nxt.rdata[KWI_REG_W-1:0] = status_view;
      end else if (hit_enable) begin
        st_nxt.rdata[PINS-1:0] = st_r.enable;
      end else if (hit_polarity) begin
        st_nxt.rdata[PINS-1:0] = st_r.polarity;
      end
    end

    // Pin readback only where direction bit is zero
    st_nxt.read_pins = det_bus.pin_level & ~port_direction_bits;

    // Request to the CPU; the block bit gates it, the flag is untouched
    st_nxt.irq = st_nxt.pending && !st_nxt.block;
  end

  // State register; reset clears request, mode, mask and all pin bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.pending <= 1'b0;
      st_r.ack_seen <= 1'b0;
      st_r.block <= KWI_RST_STATUS[KWI_BIT_MASK];
      st_r.sense_sel <= KWI_RST_STATUS[KWI_BIT_MODE];
      st_r.enable <= KWI_RST_ENABLE[PINS-1:0];
      st_r.polarity <= KWI_RST_POLARITY[PINS-1:0];
      st_r.read_pins <= '0;
      st_r.rdata <= '0;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Bus answer: zero wait states, error on unmapped addresses
  assign pready = 1'b1;
  assign pslverr = access_phase && !hit_any;
  assign prdata = st_r.rdata;

  // CPU request and wakeup; the unit never stops in wait or stop
  assign key_irq = st_r.irq;
  assign key_wakeup = st_r.irq;
  // Vector location handed to the CPU with the request
  assign vector_addr_hi = KWI_VECTOR_HI;
  assign vector_addr_lo = KWI_VECTOR_LO;

  // Enabled pins cannot be driven, whatever the direction bits say
  assign pin_drive_enable = port_direction_bits & ~st_r.enable;
  assign pin_read_data = st_r.read_pins;

  // Bias follows polarity on enabled pins only
  assign pad_pullup_en = st_r.enable & ~st_r.polarity;
  assign pad_pulldown_en = st_r.enable & st_r.polarity;

endmodule

// ---- testbench/kwi_properties.sv ----
`timescale 1ns/1ps
module kwi_properties
  import kwi_pkg::*;
#(
  parameter int PINS = KWI_PINS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [KWI_APB_AW-1:0] paddr,
  input wire logic [KWI_APB_DW-1:0] pwdata,
  input wire logic [KWI_APB_DW-1:0] prdata,
  input wire logic [PINS-1:0] watched_port_pin,
  input wire logic [PINS-1:0] port_direction_bits,
  input wire logic [PINS-1:0] pin_drive_enable,
  input wire logic [PINS-1:0] pad_pullup_en,
  input wire logic [PINS-1:0] pad_pulldown_en,
  input wire logic vector_fetch,
  input wire logic break_active,
  input wire logic break_clear_allow,
  input wire logic key_irq,
  input wire logic key_wakeup
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic st_acc, mode_s, mask_s;
  logic [PINS-1:0] lvl, lvl_q;
  logic [2:0] held, quiet;
  // Status access phase, and which enabled pins sit at their asserted level
  assign st_acc = psel && penable && paddr == (KWI_IDX_STATUS << 2);
  assign lvl = (pad_pullup_en | pad_pulldown_en) & ~(watched_port_pin ^ pad_pulldown_en);
  // Shadow bits and run lengths; counts saturate so they never wrap back to a small value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_s <= 1'b0;
      mask_s <= 1'b0;
      lvl_q <= '0;
      held <= 3'h0;
      quiet <= 3'h0;
    end else begin
      if (st_acc && pwrite) begin
        mode_s <= pwdata[KWI_BIT_MODE];
        mask_s <= pwdata[KWI_BIT_MASK];
      end
      lvl_q <= lvl;
      held <= (|lvl) ? held + 3'(held != 3'h7) : 3'h0;
      quiet <= (lvl == lvl_q) ? quiet + 3'(quiet != 3'h7) : 3'h0;
    end
  end
  pull_exclusive_a: assert property ((pad_pullup_en & pad_pulldown_en) == '0)
    else $error("pullup and pulldown both on");
  forced_input_a: assert property (pin_drive_enable == (port_direction_bits & ~(pad_pullup_en | pad_pulldown_en)))
    else $error("enabled pin still driven");
  wake_follows_a: assert property (key_wakeup == key_irq)
    else $error("wakeup differs from request");
  status_zero_a: assert property (st_acc && !pwrite |-> prdata[31:4] == '0 && !prdata[KWI_BIT_ACK])
    else $error("status reads nonzero in empty bits");
  mask_blocks_a: assert property (mask_s && $past(mask_s) |-> !key_irq)
    else $error("request passed while blocked");
  edge_ack_a: assert property (st_acc && pwrite && pwdata[KWI_BIT_ACK] && !pwdata[KWI_BIT_MODE] && !mode_s
    && quiet > 3'h4 && (!break_active || break_clear_allow) |=> !key_irq) else $error("ack did not clear");
  break_guard_a: assert property (st_acc && pwrite && break_active && !break_clear_allow && key_irq
    && !mode_s && !vector_fetch && !pwdata[KWI_BIT_MASK] |=> key_irq) else $error("ack acted during break");
  level_hold_a: assert property (mode_s && $past(mode_s) && !mask_s && !$past(mask_s) && held > 3'h5
    && key_irq && !(st_acc && pwrite) |=> key_irq) else $error("level request dropped");
endmodule
bind kwi_top kwi_properties #(.PINS(PINS)) kwi_properties_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .watched_port_pin, .port_direction_bits, .pin_drive_enable, .pad_pullup_en,
  .pad_pulldown_en, .vector_fetch, .break_active, .break_clear_allow, .key_irq, .key_wakeup);

// ---- testbench/kwi_keypad.sv ----
`timescale 1ns/1ps
module kwi_keypad (
  input wire logic pclk,
  input wire logic [7:0] key_down,
  input wire logic [7:0] pull_up,
  input wire logic [7:0] pull_down,
  output logic [7:0] pins
);
  logic [7:0] wander = 8'h55;
  // Unbiased pads float; a changing pattern stops the simulator settling them
  always @(posedge pclk) wander <= ~wander;
  // A pressed key shorts the pad to the rail opposite its bias
  always_comb pins = (key_down & pull_down) | (~key_down & (pull_up | (~pull_down & wander)));
endmodule

// ---- testbench/kwi_top_bench.sv ----
`timescale 1ns/1ps
module kwi_top_bench;
  import kwi_pkg::*;
  localparam logic [15:0] ST = KWI_IDX_STATUS << 2;
  localparam logic [15:0] EN = KWI_IDX_ENABLE << 2;
  localparam logic [15:0] PO = KWI_IDX_POLARITY << 2;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, vf = 0, brk = 0, bca = 0;
  logic pready, pslverr, irq, err;
  logic [15:0] paddr = '0;
  logic [15:0] vhi, vlo;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, q;
  logic [7:0] keys = '0;
  logic [7:0] dir = 8'hFF;
  logic [7:0] pins, drv, rdd, pu, pd;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  kwi_top kwi_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .watched_port_pin(pins), .port_direction_bits(dir), .pin_drive_enable(drv), .pin_read_data(rdd),
    .pad_pullup_en(pu), .pad_pulldown_en(pd), .vector_fetch(vf), .break_active(brk), .break_clear_allow(bca),
    .key_irq(irq), .key_wakeup(), .vector_addr_hi(vhi), .vector_addr_lo(vlo));
  kwi_keypad kwi_keypad_i (.pclk, .key_down(keys), .pull_up(pu), .pull_down(pd), .pins);
  // Clock and hang guard
  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude;
    $display("compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h, want %h", $time, g, e);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(q, e);
  endtask
  // Request checks sample at the falling edge, away from the design's updates
  task automatic poll(input logic e);
    @(negedge pclk);
    for (int i = 0; i < 12 && irq !== e; i++) @(negedge pclk);
    chk(irq, e);
    @(posedge pclk);
  endtask
  task automatic hold(input logic e);
    repeat (8) @(negedge pclk);
    chk(irq, e);
    @(posedge pclk);
  endtask
  task automatic fetch;
    vf <= 1'b1;
    @(posedge pclk);
    vf <= 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ST, 0);
    rd(EN, 0);
    rd(PO, 0);
    rd(16'h0070, 0);
    chk(err, 1);
    chk({vhi, vlo}, 32'hFFE0FFE1);
    $display("test reset done");
    // Masked setup, then unmask
    apb(1, ST, 8'h02);
    apb(1, EN, 8'h01);
    apb(1, ST, 8'h06);
    apb(1, ST, 8'h00);
    chk({pu, pd, drv, rdd}, 32'h0100FE00);
    // Pin 0 as input: its level shows on the read data one cycle later
    dir <= 8'hFE;
    repeat (2) @(negedge pclk);
    chk({drv, rdd}, 16'hFE01);
    @(posedge pclk);
    dir <= 8'hFF;
    keys <= 8'h01;
    poll(1);
    rd(ST, 8'h08);
    keys <= 8'h00;
    apb(1, ST, 8'h04);
    poll(0);
    $display("test edge done");
    // Enabling a floating pin may latch a false edge, so mask and clear it first
    apb(1, ST, 8'h02);
    apb(1, EN, 8'h03);
    apb(1, ST, 8'h06);
    apb(1, ST, 8'h00);
    keys <= 8'h02;
    poll(1);
    apb(1, ST, 8'h04);
    keys <= 8'h03;
    hold(0);
    keys <= 8'h00;
    hold(0);
    keys <= 8'h01;
    poll(1);
    keys <= 8'h00;
    apb(1, ST, 8'h02);
    apb(1, PO, 8'h01);
    apb(1, ST, 8'h06);
    apb(1, ST, 8'h00);
    chk({pu, pd}, 16'h0201);
    keys <= 8'h01;
    poll(1);
    fetch();
    poll(0);
    $display("test polarity done");
    apb(1, ST, 8'h01);
    poll(1);
    apb(1, ST, 8'h05);
    hold(1);
    apb(1, ST, 8'h03);
    hold(0);
    rd(ST, 8'h0B);
    apb(1, ST, 8'h01);
    keys <= 8'h00;
    poll(0);
    keys <= 8'h01;
    poll(1);
    keys <= 8'h00;
    hold(1);
    fetch();
    poll(0);
    $display("test level done");
    apb(1, ST, 8'h00);
    keys <= 8'h01;
    poll(1);
    brk <= 1'b1;
    apb(1, ST, 8'h04);
    hold(1);
    bca <= 1'b1;
    apb(1, ST, 8'h04);
    poll(0);
    brk <= 1'b0;
    bca <= 1'b0;
    hold(0);
    $display("test break done");
    apb(1, ST, 8'h01);
    poll(1);
    presetn <= 1'b0;
    @(negedge pclk);
    chk(irq, 0);
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ST, 0);
    $display("test reset again done");
    conclude();
  end
endmodule
